// *** design/ptm_top.sv ***
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ptm_defs.svh"
module ptm_top import ptm_pkg::*; #(
  parameter int TBC_DIV = 256
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clk_pin,
  output logic             timer_out,
  output logic             timer_out_en,
  output logic             match_a_req,
  output logic             match_p_req
);
  ptm_tick_if tk ();

  ptm_byte_t  ctrl0_reg;
  ptm_byte_t  ctrl1_reg;
  ptm_cnt_t   cnt_reg;
  ptm_cnt_t   cmpa_reg;
  ptm_cnt_t   cmpp_reg;
  logic       flag_a_reg;
  logic       flag_p_reg;
  logic       en_d_reg;
  logic       lvl_reg;
  ptm_word_t  prdata_reg;
  logic       pready_reg;
  logic       pslverr_reg;
  logic       out_reg;
  logic       oe_reg;
  logic       req_a_reg;
  logic       req_p_reg;

  logic       en;
  logic       pause;
  logic [1:0] mode;
  logic [1:0] func;
  logic       oc;
  logic       pol;
  logic       clr_a;
  logic       en_rise;
  logic       step;
  logic [10:0] cnt_inc;
  logic [10:0] period;
  logic       hit_a;
  logic       hit_p;
  logic       set_a;
  logic       set_p;
  logic       clear_cnt;
  logic       pwm_act;
  logic       wr;
  logic       setup;
  logic       mapped;
  ptm_word_t  rd_next;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  assign en      = ctrl0_reg[`PTM_C0_ENABLE];
  assign pause   = ctrl0_reg[`PTM_C0_PAUSE];
  assign mode    = ctrl1_reg[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
  assign func    = ctrl1_reg[`PTM_C1_FUNC_HI:`PTM_C1_FUNC_LO];
  assign oc      = ctrl1_reg[`PTM_C1_OC];
  assign pol     = ctrl1_reg[`PTM_C1_POL];
  assign clr_a   = ctrl1_reg[`PTM_C1_CLR] && (mode != `PTM_MODE_PWM) && (mode != `PTM_MODE_CAP);
  assign en_rise = en && !en_d_reg;

  // ---------------------------------------------------------------
  // tick source
  // ---------------------------------------------------------------
  assign tk.cksel = ctrl0_reg[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO];
  assign tk.run   = en;

  ptm_tick #(.TBC_DIV(TBC_DIV)) u_tick (
    .pclk        (pclk),
    .presetn     (presetn),
    .ext_clk_pin (ext_clk_pin),
    .tk          (tk)
  );

  // ---------------------------------------------------------------
  // match and clear logic
  // ---------------------------------------------------------------
  // gated counting
  assign step    = tk.tick && en && en_d_reg && !pause;
  assign cnt_inc = {1'b0, cnt_reg} + 11'h001;
  assign period  = (cmpp_reg == `PTM_CNT_RESET) ? `PTM_PERIOD_FULL : {1'b0, cmpp_reg};
  assign hit_a   = step && (cnt_inc == {1'b0, cmpa_reg});
  assign hit_p   = step && (cnt_inc == period);
  assign set_a   = hit_a && (mode != `PTM_MODE_CAP);
  assign set_p   = hit_p && !clr_a;
  assign clear_cnt = clr_a ? hit_a : hit_p;
  assign pwm_act = {1'b0, cnt_reg} < {1'b0, cmpa_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= `PTM_CNT_RESET;
    end else if (en_rise) begin
      cnt_reg <= `PTM_CNT_RESET;
    end else if (clear_cnt) begin
      cnt_reg <= `PTM_CNT_RESET;
    end else if (step) begin
      cnt_reg <= cnt_inc[9:0];
    end
  end

  // ---------------------------------------------------------------
  // apb slave, no wait states
  // ---------------------------------------------------------------
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite && pready_reg && !pslverr_reg;
  assign mapped = (paddr <= `PTM_ADDR_FLAGS) && (paddr[1:0] == 2'h0);

  always_comb begin
    rd_next = '0;
    if (paddr == `PTM_ADDR_CTRL0) begin
      rd_next[7:0] = ctrl0_reg;
    end else if (paddr == `PTM_ADDR_CTRL1) begin
      rd_next[7:0] = ctrl1_reg;
    end else if (paddr == `PTM_ADDR_CNT_LO) begin
      rd_next[7:0] = cnt_reg[7:0];
    end else if (paddr == `PTM_ADDR_CNT_HI) begin
      rd_next[1:0] = cnt_reg[9:8];
    end else if (paddr == `PTM_ADDR_CMPA_LO) begin
      rd_next[7:0] = cmpa_reg[7:0];
    end else if (paddr == `PTM_ADDR_CMPA_HI) begin
      rd_next[1:0] = cmpa_reg[9:8];
    end else if (paddr == `PTM_ADDR_CMPP_LO) begin
      rd_next[7:0] = cmpp_reg[7:0];
    end else if (paddr == `PTM_ADDR_CMPP_HI) begin
      rd_next[1:0] = cmpp_reg[9:8];
    end else if (paddr == `PTM_ADDR_FLAGS) begin
      rd_next[`PTM_FLAG_A] = flag_a_reg;
      rd_next[`PTM_FLAG_P] = flag_p_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup) begin
        prdata_reg <= pwrite ? '0 : rd_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `PTM_BYTE_RESET;
      ctrl1_reg <= `PTM_BYTE_RESET;
      cmpa_reg  <= `PTM_CNT_RESET;
      cmpp_reg  <= `PTM_CNT_RESET;
    end else if (wr) begin
      if (paddr == `PTM_ADDR_CTRL0) begin
        ctrl0_reg <= {pwdata[7:3], 3'h0};
      end else if (paddr == `PTM_ADDR_CTRL1) begin
        ctrl1_reg <= pwdata[7:0];
      end else if (paddr == `PTM_ADDR_CMPA_LO) begin
        cmpa_reg[7:0] <= pwdata[7:0];
      end else if (paddr == `PTM_ADDR_CMPA_HI) begin
        cmpa_reg[9:8] <= pwdata[1:0];
      end else if (paddr == `PTM_ADDR_CMPP_LO) begin
        cmpp_reg[7:0] <= pwdata[7:0];
      end else if (paddr == `PTM_ADDR_CMPP_HI) begin
        cmpp_reg[9:8] <= pwdata[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky flags, set beats clear
  // ---------------------------------------------------------------
  // sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
      req_a_reg  <= 1'b0;
      req_p_reg  <= 1'b0;
    end else begin
      req_a_reg <= set_a;
      req_p_reg <= set_p;
      if (set_a) begin
        flag_a_reg <= 1'b1;
      end else if (wr && paddr == `PTM_ADDR_FLAGS && pwdata[`PTM_FLAG_A]) begin
        flag_a_reg <= 1'b0;
      end
      if (set_p) begin
        flag_p_reg <= 1'b1;
      end else if (wr && paddr == `PTM_ADDR_FLAGS && pwdata[`PTM_FLAG_P]) begin
        flag_p_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output pin
  // ---------------------------------------------------------------
  // compare level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg <= 1'b0;
    end else if (en_rise) begin
      lvl_reg <= oc;
    end else if (set_a && mode == `PTM_MODE_CMP) begin
      case (func)
        `PTM_FN_LOW:    lvl_reg <= 1'b0;
        `PTM_FN_HIGH:   lvl_reg <= 1'b1;
        `PTM_FN_TOGGLE: lvl_reg <= !lvl_reg;
        default:        lvl_reg <= lvl_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      case (mode)
        `PTM_MODE_CMP: begin
          oe_reg  <= 1'b1;
          out_reg <= lvl_reg ^ pol;
        end
        `PTM_MODE_PWM: begin
          oe_reg <= 1'b1;
          case (func)
            `PTM_FN_ACTIVE: out_reg <= oc ^ pol;
            `PTM_FN_PWM:    out_reg <= (pwm_act ? oc : !oc) ^ pol;
            default:        out_reg <= !oc ^ pol;
          endcase
        end
        default: begin
          oe_reg  <= 1'b0;
          out_reg <= 1'b0;
        end
      endcase
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign timer_out    = out_reg;
  assign timer_out_en = oe_reg;
  assign match_a_req  = req_a_reg;
  assign match_p_req  = req_p_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic flag_a_clr;
  assign flag_a_clr = wr && paddr == `PTM_ADDR_FLAGS && pwdata[`PTM_FLAG_A];

  en_rise_zero_a: assert property (en_rise |=> cnt_reg == `PTM_CNT_RESET)
    else $error("counter not zeroed on enable rise");
  pause_hold_a: assert property (en && en_d_reg && pause |=> $stable(cnt_reg))
    else $error("counter moved while paused");
  off_hold_a: assert property (!en && !$past(en) |=> $stable(cnt_reg))
    else $error("counter moved while off");
  hi_read_zero_a: assert property (pready_reg && !pwrite && (paddr == `PTM_ADDR_CNT_HI
    || paddr == `PTM_ADDR_CMPA_HI || paddr == `PTM_ADDR_CMPP_HI) |-> prdata_reg[31:2] == 30'h0)
    else $error("upper high-byte bits not zero");
  p_clear_a: assert property (hit_p && !clr_a && !en_rise |=> cnt_reg == `PTM_CNT_RESET)
    else $error("counter not cleared at period end");
  no_p_flag_a: assert property (clr_a && !flag_p_reg |=> !flag_p_reg && !match_p_req)
    else $error("P flag raised with clear select high");
  a_zero_a: assert property (cmpa_reg == `PTM_CNT_RESET |-> !set_a)
    else $error("A flag raised with A zero");
  flag_sticky_a: assert property (flag_a_reg && !flag_a_clr |=> flag_a_reg)
    else $error("A flag lost without clear");
  req_pulse_a: assert property (set_a |=> match_a_req ##1 (flag_a_reg || !match_a_req))
    else $error("A request missing");
  tmr_release_a: assert property (mode == `PTM_MODE_TMR |=> !timer_out_en)
    else $error("pin driven in timer mode");
  toggle_out_a: assert property (set_a && mode == `PTM_MODE_CMP && func == `PTM_FN_TOGGLE && !en_rise
    && $stable(lvl_reg) && $stable(pol) && $past(mode) == `PTM_MODE_CMP
    ##1 mode == `PTM_MODE_CMP && $stable(pol) |=> timer_out != $past(timer_out, 2))
    else $error("pin did not toggle on A match");
  full_duty_a: assert property ((mode == `PTM_MODE_PWM && func == `PTM_FN_PWM
    && {1'b0, cmpa_reg} >= period && {1'b0, cnt_reg} < period && $stable(ctrl1_reg)) [*2]
    |-> timer_out == (oc ^ pol))
    else $error("full duty not held");
  apb_ready_a: assert property (setup |=> pready_reg)
    else $error("no ready after setup");
  a_clear_a: assert property (hit_a && clr_a && !en_rise |=> cnt_reg == `PTM_CNT_RESET)
    else $error("counter not cleared on A match");
  count_step_a: assert property (step && !clear_cnt && !en_rise
    |=> cnt_reg == $past(cnt_reg) + 10'h001)
    else $error("counter did not advance on tick");
  set_wins_a: assert property (set_a |=> flag_a_reg && match_a_req)
    else $error("A flag or request not raised");
  p_flag_set_a: assert property (set_p |=> flag_p_reg && match_p_req)
    else $error("P flag or request not raised");
  off_tick_a: assert property (!en |=> !tk.tick)
    else $error("tick generated while off");
  drive_en_a: assert property (mode == `PTM_MODE_CMP || mode == `PTM_MODE_PWM |=> timer_out_en)
    else $error("pin not driven in output mode");
  forced_level_a: assert property (mode == `PTM_MODE_PWM && func == `PTM_FN_ACTIVE
    |=> timer_out == $past(oc ^ pol))
    else $error("forced active level not driven");

  // ---------------------------------------------------------------
  // scenario coverage
  // ---------------------------------------------------------------
  pwm_wrap_c: cover property (mode == `PTM_MODE_PWM && hit_p);
  ext_tick_c: cover property (tk.tick && tk.cksel == `PTM_CK_EXT_RISE);
  full_duty_c: cover property (mode == `PTM_MODE_PWM && {1'b0, cmpa_reg} >= period && hit_p);
  cmp_a_c: cover property (mode == `PTM_MODE_CMP && set_a && func == `PTM_FN_TOGGLE);
  clr_race_c: cover property (set_a && flag_a_clr);
endmodule : ptm_top

// *** inc/ptm_defs.svh ***
// Summary of operation
// - counter readable as low and high bytes
// - unused high byte bits read zero
// - comparison value A, two writable bytes
// - comparison value P, two writable bytes
// - mode 00 compare-match output, two clears
// - clear on P match, overflow if P zero
// - both A and P flags raised
// - clear-select high: clear on A, A only
// - A zero overflows at 3FF, no A flag
// - pin changes only on A match flag
// - output function sets, clears or toggles pin
// - enable rise loads initial pin level
// - mode 11 counts like 00, pin released
// - PWM: P sets period, A sets duty
// - P zero gives 1024-clock period
// - A at least period gives full duty
// - PWM raises A and P flags
// - PWM level, forcing and inversion controls
// - forced pin keeps internal counting alive
// - enable rise zeroes counter, fall holds
// - pause holds counter, resume continues
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define PTM_ADDR_CTRL0    8'h00
`define PTM_ADDR_CTRL1    8'h04
`define PTM_ADDR_CNT_LO   8'h08
`define PTM_ADDR_CNT_HI   8'h0C
`define PTM_ADDR_CMPA_LO  8'h10
`define PTM_ADDR_CMPA_HI  8'h14
`define PTM_ADDR_CMPP_LO  8'h18
`define PTM_ADDR_CMPP_HI  8'h1C
`define PTM_ADDR_FLAGS    8'h20

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PTM_C0_PAUSE      7
`define PTM_C0_CKSEL_HI   6
`define PTM_C0_CKSEL_LO   4
`define PTM_C0_ENABLE     3
`define PTM_C1_MODE_HI    7
`define PTM_C1_MODE_LO    6
`define PTM_C1_FUNC_HI    5
`define PTM_C1_FUNC_LO    4
`define PTM_C1_OC         2'd3
`define PTM_C1_POL        2'd2
`define PTM_C1_CLR        0
`define PTM_FLAG_A        0
`define PTM_FLAG_P        1

// ---------------------------------------------------------------
// encodings and reset values
// ---------------------------------------------------------------
`define PTM_MODE_CMP      2'h0
`define PTM_MODE_CAP      2'h1
`define PTM_MODE_PWM      2'h2
`define PTM_MODE_TMR      2'h3
`define PTM_FN_NONE       2'h0
`define PTM_FN_LOW        2'h1
`define PTM_FN_HIGH       2'h2
`define PTM_FN_TOGGLE     2'h3
`define PTM_FN_INACTIVE   2'h0
`define PTM_FN_ACTIVE     2'h1
`define PTM_FN_PWM        2'h2
`define PTM_CK_SYS4       3'h0
`define PTM_CK_SYS        3'h1
`define PTM_CK_H16        3'h2
`define PTM_CK_H64        3'h3
`define PTM_CK_TBC0       3'h4
`define PTM_CK_TBC1       3'h5
`define PTM_CK_EXT_RISE   3'h6
`define PTM_CK_EXT_FALL   3'h7
`define PTM_BYTE_RESET    8'h00
`define PTM_CNT_RESET     10'h000
`define PTM_CNT_MAX       10'h3FF
`define PTM_PERIOD_FULL   11'h400
`define PTM_PRE_MASK4     6'h03
`define PTM_PRE_MASK16    6'h0F
`define PTM_PRE_MASK64    6'h3F

`endif

// *** inc/ptm_pkg.sv ***
package ptm_pkg;
  typedef logic [9:0]  ptm_cnt_t;
  typedef logic [7:0]  ptm_byte_t;
  typedef logic [2:0]  ptm_cksel_t;
  typedef logic [31:0] ptm_word_t;
endpackage : ptm_pkg

// *** inc/ptm_tick_if.sv ***
`timescale 1ns/1ps
interface ptm_tick_if;
  import ptm_pkg::*;
  ptm_cksel_t cksel;
  logic       run;
  logic       tick;
  modport core (output cksel, output run, input tick);
  modport gen  (input cksel, input run, output tick);
endinterface : ptm_tick_if

// *** design/ptm_tick.sv ***
`timescale 1ns/1ps
`include "ptm_defs.svh"
module ptm_tick import ptm_pkg::*; #(
  parameter int TBC_DIV = 256
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  ext_clk_pin,
  ptm_tick_if.gen    tk
);
  localparam int TW = $clog2(TBC_DIV);

  logic [5:0]    pre_reg;
  logic [TW-1:0] tbc_reg;
  logic [2:0]    sync_reg;
  logic          lvl_reg;
  logic          tick_next;
  logic          tick_reg;

  // ---------------------------------------------------------------
  // free prescalers, idle while powered down
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
      tbc_reg <= '0;
    end else if (tk.run) begin
      pre_reg <= pre_reg + 6'h01;
      tbc_reg <= (tbc_reg == TW'(TBC_DIV - 1)) ? '0 : tbc_reg + TW'(1);
    end
  end

  // ---------------------------------------------------------------
  // pin clock synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= 3'h0;
      lvl_reg  <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], ext_clk_pin};
      if (sync_reg[1] == sync_reg[2]) begin
        lvl_reg <= sync_reg[2];
      end
    end
  end

  always_comb begin
    tick_next = 1'b0;
    case (tk.cksel)
      `PTM_CK_SYS4:     tick_next = (pre_reg & `PTM_PRE_MASK4) == `PTM_PRE_MASK4;
      `PTM_CK_SYS:      tick_next = 1'b1;
      `PTM_CK_H16:      tick_next = (pre_reg & `PTM_PRE_MASK16) == `PTM_PRE_MASK16;
      `PTM_CK_H64:      tick_next = pre_reg == `PTM_PRE_MASK64;
      `PTM_CK_TBC0,
      `PTM_CK_TBC1:     tick_next = tbc_reg == TW'(TBC_DIV - 1);
      `PTM_CK_EXT_RISE: tick_next = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !lvl_reg;
      default:          tick_next = (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && lvl_reg;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next && tk.run;
    end
  end

  assign tk.tick = tick_reg;
endmodule : ptm_tick

// *** verification/tb_ptm_top.sv ***
`timescale 1ns/1ps
`include "ptm_defs.svh"
module tb_ptm_top import ptm_pkg::*; ;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_clk_pin;
  logic        timer_out;
  logic        timer_out_en;
  logic        match_a_req;
  logic        match_p_req;
  int          n_mismatch;
  int          check_count;
  logic [2:0]  tick_sel;

  ptm_top #(.TBC_DIV(4)) ptm_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_pin(ext_clk_pin), .timer_out(timer_out), .timer_out_en(timer_out_en),
    .match_a_req(match_a_req), .match_p_req(match_p_req)
  );

  always #2 pclk = ~pclk;

  // pin clock source, one rising edge every six cycles
  initial begin
    ext_clk_pin = 1'b0;
    forever begin
      repeat (3) @(posedge pclk);
      ext_clk_pin <= ~ext_clk_pin;
    end
  end

  // ---------------------------------------------------------------
  // reporting and bus cycles
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic timeout(input string name);
    n_mismatch++;
    $display("mismatch %s expected event seen timeout", name);
    tally_and_finish();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) timeout("pready");
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    check(name, exp, r);
  endtask

  // off, program, clear flags, then an enable rise
  task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
    wr(`PTM_ADDR_CTRL0, {25'h000_0000, tick_sel, 4'h0});
    wr(`PTM_ADDR_CTRL1, {24'h00_0000, c1});
    wr(`PTM_ADDR_CMPA_LO, {24'h00_0000, a[7:0]});
    wr(`PTM_ADDR_CMPA_HI, {30'h0000_0000, a[9:8]});
    wr(`PTM_ADDR_CMPP_LO, {24'h00_0000, p[7:0]});
    wr(`PTM_ADDR_CMPP_HI, {30'h0000_0000, p[9:8]});
    wr(`PTM_ADDR_FLAGS, 32'h0000_0003);
    wr(`PTM_ADDR_CTRL0, {25'h000_0000, tick_sel, 4'h8});
  endtask

  // count cycles, requests and high pin cycles over nper periods
  task automatic measure(input bit on_a, input int nper, output int gap, output int na,
                         output int np, output int nh);
    int i;
    int seen;
    for (i = 0; i < 3000; i++) begin
      @(posedge pclk);
      if ((on_a ? match_a_req : match_p_req) === 1'b1) break;
    end
    if (i == 3000) timeout("match request");
    gap = 0;
    na = 0;
    np = 0;
    nh = 0;
    seen = 0;
    for (i = 0; i < 3000 && seen < nper; i++) begin
      @(posedge pclk);
      gap++;
      if (match_a_req === 1'b1) na++;
      if (match_p_req === 1'b1) np++;
      if (timer_out === 1'b1) nh++;
      if ((on_a ? match_a_req : match_p_req) === 1'b1) seen++;
    end
    if (seen < nper) timeout("match period");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    for (int k = 0; k < 6; k++) begin
      rd_chk("reset value", 8'(`PTM_ADDR_CNT_LO + 4 * k), 32'h0000_0000);
    end
    wr(`PTM_ADDR_CMPA_LO, 32'hFFFF_FFA5);
    rd_chk("a low", `PTM_ADDR_CMPA_LO, 32'h0000_00A5);
    wr(`PTM_ADDR_CMPA_HI, 32'hFFFF_FFFF);
    rd_chk("a high", `PTM_ADDR_CMPA_HI, 32'h0000_0003);
    wr(`PTM_ADDR_CMPP_LO, 32'h0000_005A);
    rd_chk("p low", `PTM_ADDR_CMPP_LO, 32'h0000_005A);
    wr(`PTM_ADDR_CMPP_HI, 32'h0000_00FE);
    rd_chk("p high", `PTM_ADDR_CMPP_HI, 32'h0000_0002);
    wr(`PTM_ADDR_CNT_LO, 32'h0000_00FF);
    rd_chk("counter read only", `PTM_ADDR_CNT_LO, 32'h0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000, r, e);
    check("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
  endtask

  task automatic t_cmp();
    int         g;
    int         na;
    int         np;
    int         nh;
    int         nper;
    logic [1:0] f;
    int         exp_h [4] = '{5, 0, 5, 5};
    for (int k = 0; k < 4; k++) begin
      f = 2'(k);
      nper = (k == 3) ? 2 : 1;
      setup({2'b00, f, (f != `PTM_FN_HIGH), 3'b000}, 10'd3, 10'd5);
      measure(1'b0, nper, g, na, np, nh);
      check("cmp period", 32'(5 * nper), 32'(g));
      check("cmp a matches", 32'(nper), 32'(na));
      check("cmp pin high", 32'(exp_h[k]), 32'(nh));
      check("cmp pin enable", 32'h0000_0001, {31'h0000_0000, timer_out_en});
    end
    rd_chk("cmp flags", `PTM_ADDR_FLAGS, 32'h0000_0003);
    setup(8'h01, 10'd4, 10'd2);
    measure(1'b1, 1, g, na, np, nh);
    check("clr a period", 32'h0000_0004, 32'(g));
    check("clr no p", 32'h0000_0000, 32'(np));
    rd_chk("clr flags", `PTM_ADDR_FLAGS, 32'h0000_0001);
    setup(8'h18, 10'd0, 10'd0);
    measure(1'b0, 1, g, na, np, nh);
    check("overflow period", 32'h0000_0400, 32'(g));
    check("a zero no match", 32'h0000_0000, 32'(na));
    check("initial level held", 32'h0000_0400, 32'(nh));
  endtask

  task automatic t_tmr();
    int          g;
    int          na;
    int          np;
    int          nh;
    logic [31:0] v1;
    logic [31:0] v2;
    setup(8'hC0, 10'd3, 10'd5);
    measure(1'b0, 1, g, na, np, nh);
    check("tmr period", 32'h0000_0005, 32'(g));
    check("tmr a matches", 32'h0000_0001, 32'(na));
    check("tmr pin released", 32'h0000_0000, {31'h0000_0000, timer_out_en});
    setup(8'hC0, 10'd0, 10'd0);
    repeat (300) @(posedge pclk);
    rd_chk("counter high", `PTM_ADDR_CNT_HI, 32'h0000_0001);
    wr(`PTM_ADDR_CTRL0, 32'h0000_0098);
    rd(`PTM_ADDR_CNT_LO, v1);
    repeat (8) @(posedge pclk);
    rd_chk("paused", `PTM_ADDR_CNT_LO, v1);
    wr(`PTM_ADDR_CTRL0, 32'h0000_0018);
    rd(`PTM_ADDR_CNT_LO, v2);
    check("resumed", 32'h0000_0001, {31'h0000_0000, (v2 > v1) && (v2 - v1 < 8)});
    wr(`PTM_ADDR_CTRL0, 32'h0000_0010);
    rd(`PTM_ADDR_CNT_LO, v1);
    repeat (8) @(posedge pclk);
    rd_chk("disabled hold", `PTM_ADDR_CNT_LO, v1);
    wr(`PTM_ADDR_CTRL0, 32'h0000_0018);
    rd(`PTM_ADDR_CNT_LO, v2);
    check("enable zeroes", 32'h0000_0001, {31'h0000_0000, v2 < 8});
    rd_chk("enable zeroes high", `PTM_ADDR_CNT_HI, 32'h0000_0000);
  endtask

  task automatic t_pwm();
    int          g;
    int          na;
    int          np;
    int          nh;
    logic [7:0]  c1 [7] = '{8'hA8, 8'hA8, 8'hAC, 8'h98, 8'h88, 8'hA9, 8'hA8};
    logic [9:0]  av [7] = '{10'd3, 10'd9, 10'd3, 10'd3, 10'd3, 10'd3, 10'h200};
    logic [9:0]  pv [7] = '{10'd8, 10'd8, 10'd8, 10'd8, 10'd8, 10'd8, 10'd0};
    int          eg [7] = '{8, 8, 8, 8, 8, 8, 1024};
    int          eh [7] = '{3, 8, 5, 8, 0, 3, 512};
    int          ea [7] = '{1, 0, 1, 1, 1, 1, 1};
    for (int k = 0; k < 7; k++) begin
      setup(c1[k], av[k], pv[k]);
      measure(1'b0, 1, g, na, np, nh);
      check("pwm period", 32'(eg[k]), 32'(g));
      check("pwm duty", 32'(eh[k]), 32'(nh));
      check("pwm a matches", 32'(ea[k]), 32'(na));
    end
    check("pwm pin enable", 32'h0000_0001, {31'h0000_0000, timer_out_en});
  endtask

  // every counter clock select except PTM_CK_SYS, timer mode, period of five ticks
  task automatic t_clk();
    int          g;
    int          na;
    int          np;
    int          nh;
    logic [2:0]  cs [7] = '{`PTM_CK_SYS4, `PTM_CK_H16, `PTM_CK_H64, `PTM_CK_TBC0, `PTM_CK_TBC1,
                            `PTM_CK_EXT_RISE, `PTM_CK_EXT_FALL};
    int          ediv [7] = '{4, 16, 64, 4, 4, 6, 6};
    for (int k = 0; k < 7; k++) begin
      tick_sel = cs[k];
      setup(8'hC0, 10'd3, 10'd5);
      measure(1'b0, 1, g, na, np, nh);
      check("tick period", 32'(5 * ediv[k]), 32'(g));
      check("tick a matches", 32'h0000_0001, 32'(na));
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tick_sel = `PTM_CK_SYS;
    n_mismatch = 0;
    check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cmp();
    t_tmr();
    t_pwm();
    t_clk();
    tally_and_finish();
  end
endmodule // tb_ptm_top
